// File: rtl/prot_cfg.svh
// Constants for the protection bypass interlock: modes, offsets, reset values, timing.
`ifndef PROT_CFG_SVH
`define PROT_CFG_SVH
`define CLK_HZ 20000000
`define SD_DELAY_S 10
`define MODE_SHUTDOWN 2'h0
`define MODE_REFUEL 2'h1
`define MODE_STARTUP 2'h2
`define MODE_RUN 2'h3
`define OFS_STATUS 8'h00
`define OFS_ALARM 8'h04
`define OFS_STAGGER 8'h08
`define STAGGER_RST 16'h0100
`define HTRANS_NONSEQ_BIT 1
`define TLU_RST 4'hF
`define MAN_RST 2'h3
`endif

// File: rtl/prot_pkg.sv
// Types shared by the protection bypass interlock design.
package prot_pkg;
  typedef logic [1:0] mode_type;
  typedef enum logic [2:0] {
    STG_OFF = 3'b001,
    STG_HALF = 3'b010,
    STG_FULL = 3'b100
  } stagger_state_type;
endpackage

// File: rtl/protection_bypass_interlock.sv
// Maintenance bypass interlocks, trip voting, mode switch logic and trip seal-in.
// What this block does
// - Only one sensor-division bypass at a time; other requests inhibited.
// - With a sensor bypass, vote becomes two-out-of-three of remaining divisions.
// - Sensor bypass masks all trip inputs from that division at each logic unit.
// - A bypass switch with lost communication counts as no bypass.
// - Every active maintenance bypass alarms; sensor alarm names the division.
// - Out-of-service bypass masks one logic unit output; one at a time; alarmed.
// - An out-of-service division still trips on its manual trip.
// - Sensor and out-of-service interlocks are independent and may coexist.
// - Two unbypassed trips always scram; no bypass removes a scram function.
// - Automatic trip reset is accepted only after trip inputs have cleared.
// - Shutdown mode position initiates a scram.
// - Shutdown/refuel enable non-coincident, accumulator bypass, valve/bus bypass.
// - Startup enables non-coincident and valve/bus bypass, disables accumulator bypass.
// - Run disables all those bypasses and bypasses startup-range monitor trips.
// - Two manual scram inputs scram regardless of any other channel state.
// - Each divisional manual trip trips that division's actuators.
// - Any two divisional manual trips give a full scram.
// - Trips seal in until reset by up to five reset inputs.
// - Manual reset clears both manual trips, re-energizing two groups at a time.
// - Four divisional resets each clear that division's sealed automatic trip.
// - Two manual switches suppress the shutdown-position scram, for outages only.
// - Shutdown scram self-bypasses after about ten seconds, with indication.
// - Startup/run remove accumulator bypass; alarm if a switch is left in bypass.
// - Run forces coincident monitor trips; alarm if a selector says non-coincident.
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "prot_cfg.svh"
module protection_bypass_interlock #(
  parameter int PARAMS = 4,
  parameter int TIMER_W = 28,
  parameter logic [TIMER_W-1:0] SD_DELAY_CYCLES = TIMER_W'(`SD_DELAY_S * `CLK_HZ)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [4*PARAMS-1:0] sensTrip,
  input wire logic [3:0] sensBypSw,
  input wire logic [3:0] sensBypComm,
  input wire logic [3:0] oosBypSw,
  input wire logic [3:0] oosBypComm,
  input wire prot_pkg::mode_type modeSel,
  input wire logic [3:0] divManTrip,
  input wire logic [1:0] manScram,
  input wire logic manReset,
  input wire logic [3:0] divReset,
  input wire logic [1:0] sdBypSw,
  input wire logic [3:0] accumBypSw,
  input wire logic [3:0] nonCoincSel,
  output logic [3:0] divActTrip,
  output logic fullScram,
  output logic [3:0] solenoidOn,
  output logic [3:0] sensBypAlarm,
  output logic [3:0] oosAlarm,
  output logic sdBypIndicate,
  output logic nonCoincEnable,
  output logic [3:0] accumBypActive,
  output logic valveBusBypEnable,
  output logic startupMonBypass,
  output logic accumSwAlarm,
  output logic coincSelAlarm
);
  import prot_pkg::*;

  localparam int IN_W = 4 * PARAMS + 39;

  function automatic logic atLeastTwo(input logic [3:0] v);
    atLeastTwo = (v[0] & (v[1] | v[2] | v[3])) | (v[1] & (v[2] | v[3])) | (v[2] & v[3]);
  endfunction

  // Holds an established bypass while its request stays; grants a lone new request.
  function automatic logic [3:0] grantOne(input logic [3:0] req, input logic [3:0] cur);
    logic [3:0] g;
    g = 4'h0;
    if (cur != 4'h0) begin
      g = cur & req;
    end else if (req != 4'h0 && (req & (req - 4'h1)) == 4'h0) begin
      g = req;
    end
    grantOne = g;
  endfunction

  // Every field input pin passes two flops before any logic looks at it; the AHB pins are used directly.
  logic [IN_W-1:0] syncA_reg;
  logic [IN_W-1:0] syncB_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= {sensTrip, sensBypSw, sensBypComm, oosBypSw, oosBypComm, modeSel,
                    divManTrip, manScram, manReset, divReset, sdBypSw, accumBypSw,
                    nonCoincSel};
      syncB_reg <= syncA_reg;
    end
  end

  wire logic [4*PARAMS-1:0] sTrip;
  wire logic [3:0] sSensSw;
  wire logic [3:0] sSensComm;
  wire logic [3:0] sOosSw;
  wire logic [3:0] sOosComm;
  wire mode_type sMode;
  wire logic [3:0] sDivMan;
  wire logic [1:0] sManScram;
  wire logic sManReset;
  wire logic [3:0] sDivReset;
  wire logic [1:0] sSdByp;
  wire logic [3:0] sAccumSw;
  wire logic [3:0] sNonCoinc;
  assign {sTrip, sSensSw, sSensComm, sOosSw, sOosComm, sMode, sDivMan, sManScram,
          sManReset, sDivReset, sSdByp, sAccumSw, sNonCoinc} = syncB_reg;

  wire logic [3:0] sensReq = sSensSw & sSensComm;
  wire logic [3:0] oosReq = sOosSw & sOosComm;

  logic [3:0] sensByp_reg;
  logic [3:0] oosByp_reg;
  wire logic [3:0] sensByp_next = grantOne(sensReq, sensByp_reg);
  wire logic [3:0] oosByp_next = grantOne(oosReq, oosByp_reg);

  logic [PARAMS-1:0] paramTrip;
  always_comb begin
    for (int p = 0; p < PARAMS; p++) begin
      paramTrip[p] = atLeastTwo({sTrip[3*PARAMS+p], sTrip[2*PARAMS+p],
                                 sTrip[PARAMS+p], sTrip[p]} & ~sensByp_reg);
    end
  end
  wire logic autoTrip = |paramTrip;

  // Mode switch decode.
  wire logic modeSd = (sMode == `MODE_SHUTDOWN);
  wire logic modeRefuel = (sMode == `MODE_REFUEL);
  wire logic modeStartup = (sMode == `MODE_STARTUP);
  wire logic modeRun = (sMode == `MODE_RUN);

  logic [TIMER_W-1:0] sdTimer_reg;
  wire logic sdTimeUp = (sdTimer_reg >= SD_DELAY_CYCLES);
  wire logic [TIMER_W-1:0] sdTimer_next =
      !modeSd ? '0 : (sdTimeUp ? sdTimer_reg : sdTimer_reg + TIMER_W'(1));
  wire logic sdScram = modeSd & ~sdTimeUp & ~(|sSdByp);

  // Sealed-in trip systems; in each a new trip wins over a same-cycle reset.
  logic [3:0] tluSeal_reg;
  logic [3:0] divMan_reg;
  logic [1:0] manTrip_reg;
  logic manResetD_reg;
  wire logic manResetPulse = sManReset & ~manResetD_reg;
  wire logic [3:0] tluSeal_next = {4{autoTrip}} |
                                  (tluSeal_reg & ~(sDivReset & {4{~autoTrip}}));
  wire logic [3:0] divMan_next = sDivMan | (divMan_reg & ~(sDivReset & ~sDivMan));
  wire logic [1:0] manSet = sManScram | {2{sdScram}};
  wire logic [1:0] manTrip_next = manSet | (manTrip_reg & ~{2{manResetPulse}});

  wire logic [3:0] divOut = (tluSeal_reg & ~oosByp_reg) | divMan_reg;
  wire logic scramNext = atLeastTwo(divOut) | atLeastTwo(divMan_reg) | (|manTrip_reg) |
                         (|sManScram);
  // A manual reset clears the manual seal in the cycle it starts the stagger, so the
  // sequencer judges by the seal that follows; otherwise no reset could ever start it.
  wire logic scramHold = atLeastTwo(divOut) | atLeastTwo(divMan_reg) | (|manTrip_next) |
                         (|sManScram);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sensByp_reg <= 4'h0;
      oosByp_reg <= 4'h0;
      sdTimer_reg <= '0;
      tluSeal_reg <= `TLU_RST;
      divMan_reg <= 4'h0;
      manTrip_reg <= `MAN_RST;
      manResetD_reg <= 1'b0;
      divActTrip <= `TLU_RST;
      fullScram <= 1'b1;
    end else begin
      sensByp_reg <= sensByp_next;
      oosByp_reg <= oosByp_next;
      sdTimer_reg <= sdTimer_next;
      tluSeal_reg <= tluSeal_next;
      divMan_reg <= divMan_next;
      manTrip_reg <= manTrip_next;
      manResetD_reg <= sManReset;
      divActTrip <= divOut;
      fullScram <= scramNext;
    end
  end

  logic [15:0] stagger_reg;
  logic [3:0] groupOn;
  solenoid_stagger u_stagger (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(manResetPulse),
    .abort(scramHold),
    .interval(stagger_reg),
    .groupOn(groupOn)
  );

  // Mode-dependent bypass permits and alarms.
  // non-coincident and valve/bus all but run; accumulator shutdown/refuel; accumulator alarm startup/run, coincidence alarm run
  wire logic ncEn_next = ~modeRun;
  wire logic accumEn = modeSd | modeRefuel;
  wire logic vbEn_next = ~modeRun;
  wire logic accumAlarm_next = (modeStartup | modeRun) & (|sAccumSw);
  wire logic coincAlarm_next = modeRun & (|sNonCoinc);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      solenoidOn <= 4'h0;
      sensBypAlarm <= 4'h0;
      oosAlarm <= 4'h0;
      sdBypIndicate <= 1'b0;
      nonCoincEnable <= 1'b0;
      accumBypActive <= 4'h0;
      valveBusBypEnable <= 1'b0;
      startupMonBypass <= 1'b0;
      accumSwAlarm <= 1'b0;
      coincSelAlarm <= 1'b0;
    end else begin
      solenoidOn <= groupOn & {4{~scramNext}};
      sensBypAlarm <= sensByp_reg;
      oosAlarm <= oosByp_reg;
      sdBypIndicate <= modeSd & (sdTimeUp | (|sSdByp));
      nonCoincEnable <= ncEn_next;
      accumBypActive <= sAccumSw & {4{accumEn}};
      valveBusBypEnable <= vbEn_next;
      startupMonBypass <= modeRun;
      accumSwAlarm <= accumAlarm_next;
      coincSelAlarm <= coincAlarm_next;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY, unmapped words read zero.
  logic dWrite_reg;
  logic dRead_reg;
  logic [7:0] dAddr_reg;
  wire logic aValid = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  wire logic [31:0] statusWord = {8'h00, sensByp_reg, oosByp_reg, 2'h0, sMode,
                                  manTrip_reg, sdBypIndicate, fullScram,
                                  divMan_reg, tluSeal_reg};
  wire logic [31:0] alarmWord = {20'h00000, accumSwAlarm, coincSelAlarm,
                                 startupMonBypass, valveBusBypEnable,
                                 accumBypActive, solenoidOn};
  wire logic [31:0] rdMux = (dAddr_reg == `OFS_STATUS) ? statusWord :
                            (dAddr_reg == `OFS_ALARM) ? alarmWord :
                            (dAddr_reg == `OFS_STAGGER) ? {16'h0000, stagger_reg} :
                            32'h00000000;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = dRead_reg ? rdMux : 32'h00000000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dWrite_reg <= 1'b0;
      dRead_reg <= 1'b0;
      dAddr_reg <= 8'h00;
      stagger_reg <= `STAGGER_RST;
    end else begin
      if (hready) begin
        dWrite_reg <= aValid & hwrite;
        dRead_reg <= aValid & ~hwrite;
        dAddr_reg <= {haddr[7:2], 2'h0};
      end
      if (dWrite_reg && dAddr_reg == `OFS_STAGGER) begin
        stagger_reg <= hwdata[15:0];
      end
    end
  end
endmodule // protection_bypass_interlock

// File: rtl/solenoid_stagger.sv
// Staggered re-energization sequencer for the four scram pilot solenoid groups.
`timescale 1ns/1ps
module solenoid_stagger (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic [15:0] interval,
  output logic [3:0] groupOn
);
  import prot_pkg::*;
  stagger_state_type state_reg;
  stagger_state_type state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [3:0] groupOn_next;
  wire logic waitDone = (cnt_reg >= interval);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      STG_OFF: begin
        cnt_next = 16'h0000;
        if (start && !abort) begin
          state_next = STG_HALF;
        end
      end
      STG_HALF: begin
        cnt_next = cnt_reg + 16'h0001;
        if (abort) begin
          state_next = STG_OFF;
        end else if (waitDone) begin
          state_next = STG_FULL;
        end
      end
      STG_FULL: begin
        if (abort) begin
          state_next = STG_OFF;
        end
      end
      default: begin
        state_next = STG_OFF;
      end
    endcase
  end

  assign groupOn_next = (state_next == STG_FULL) ? 4'hF :
                        (state_next == STG_HALF) ? 4'h3 : 4'h0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= STG_OFF;
      cnt_reg <= 16'h0000;
      groupOn <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      groupOn <= groupOn_next;
    end
  end
endmodule // solenoid_stagger

// File: tb/console_model.sv
// Control-room switch panel driving the bypass switches and their links.
`timescale 1ns/1ps
module console_model (
  input wire logic sys_clk,
  input wire logic [3:0] sensReq,
  input wire logic [3:0] oosReq,
  input wire logic [3:0] linkLost,
  input wire logic outage,
  input wire logic [1:0] sdReq,
  output logic [3:0] sensBypSw = 4'h0,
  output logic [3:0] sensBypComm = 4'h0,
  output logic [3:0] oosBypSw = 4'h0,
  output logic [3:0] oosBypComm = 4'h0,
  output logic [1:0] sdBypSw = 2'h0
);
  logic toggle = 1'b0;
  // A switch whose link is lost shows a wandering level, never a clean idle.
  always @(posedge sys_clk) begin
    toggle <= !toggle;
    sensBypComm <= ~linkLost;
    oosBypComm <= ~linkLost;
    sensBypSw <= sensReq | (linkLost & {4{toggle}});
    oosBypSw <= oosReq | (linkLost & {4{toggle}});
    sdBypSw <= outage ? sdReq : 2'h0;
  end
endmodule // console_model

// File: tb/protection_bypass_interlock_props.sv
// Concurrent checks on the ports of the protection bypass interlock.
`timescale 1ns/1ps
`include "prot_cfg.svh"
module protection_bypass_interlock_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire prot_pkg::mode_type modeSel,
  input wire logic [3:0] accumBypSw,
  input wire logic [1:0] manScram,
  input wire logic [3:0] divManTrip,
  input wire logic fullScram,
  input wire logic [3:0] divActTrip,
  input wire logic [3:0] solenoidOn,
  input wire logic [3:0] sensBypAlarm,
  input wire logic [3:0] oosAlarm,
  input wire logic nonCoincEnable,
  input wire logic valveBusBypEnable,
  input wire logic startupMonBypass,
  input wire logic [3:0] accumBypActive,
  input wire logic accumSwAlarm
);
  import prot_pkg::*;
  logic [2:0] upCnt;
  logic up;
  // Input synchronisers still hold reset values for a few cycles after release.
  assign up = &upCnt;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      upCnt <= 3'h0;
    else if (!up)
      upCnt <= upCnt + 3'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_sens_single_bypass: assert property ($onehot0(sensBypAlarm))
    else $error("more than one sensor division bypassed");
  a_oos_single_bypass: assert property ($onehot0(oosAlarm))
    else $error("more than one division out of service");
  a_manual_scram: assert property (up && |manScram |-> ##3 fullScram)
    else $error("manual scram did not scram");
  a_div_manual_trip: assert property (up && divManTrip[0] |-> ##4 divActTrip[0])
    else $error("divisional manual trip did not trip its actuators");
  a_two_manual_trips: assert property (up && $countones(divManTrip) > 1 |-> ##4 fullScram)
    else $error("two divisional manual trips gave no scram");
  a_run_enables: assert property ((modeSel == `MODE_RUN) [*4] |->
    startupMonBypass && !nonCoincEnable && !valveBusBypEnable)
    else $error("run position enables wrong");
  a_other_enables: assert property ((modeSel != `MODE_RUN) [*4] |->
    !startupMonBypass && nonCoincEnable && valveBusBypEnable)
    else $error("non-run position enables wrong");
  a_accum_removed: assert property ((modeSel[1] && |accumBypSw) [*4] |->
    accumBypActive == 4'h0 && accumSwAlarm)
    else $error("accumulator bypass kept in startup or run");
  a_stagger_pairs: assert property (solenoidOn == 4'h0 |=> solenoidOn != 4'hF)
    else $error("all solenoid groups energised together");
  c_scram_clear: cover property (fullScram ##1 !fullScram);
  c_both_bypass: cover property (sensBypAlarm != 4'h0 && oosAlarm != 4'h0);
  c_pair_on: cover property (solenoidOn == 4'h3);
endmodule // protection_bypass_interlock_props
bind protection_bypass_interlock protection_bypass_interlock_props u_props (.*);

// File: tb/protection_bypass_interlock_test.sv
// Self-checking bench for the protection bypass interlock.
`timescale 1ns/1ps
`include "prot_cfg.svh"
module protection_bypass_interlock_test;
  import prot_pkg::*;
  typedef struct packed {
    mode_type m;
    logic [3:0] ncs;
    logic [3:0] acc;
    logic [2:0] en;
    logic [1:0] alm;
    logic [3:0] act;
  } row_type;
  // Shutdown bypass delay shortened to 20 cycles to keep the run short.
  localparam int SD = 20;
  row_type rows [4] = '{'{`MODE_REFUEL, 4'hF, 4'hA, 3'h6, 2'h0, 4'hA},
    '{`MODE_STARTUP, 4'hF, 4'h3, 3'h6, 2'h1, 4'h0}, '{`MODE_RUN, 4'h2, 4'h8, 3'h1, 2'h3, 4'h0},
    '{`MODE_SHUTDOWN, 4'h0, 4'h5, 3'h6, 2'h0, 4'h5}};
  logic sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, manReset = 1'b0, outage = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, manScram = 2'h0, sdReq = 2'h0, sdBypSw;
  logic [2:0] hsize = 3'h2;
  logic [15:0] sensTrip = 16'h0;
  mode_type modeSel = `MODE_REFUEL;
  logic [3:0] divManTrip = 4'h0, divReset = 4'h0, accumBypSw = 4'h0, nonCoincSel = 4'h0;
  logic [3:0] sensReq = 4'h0, oosReq = 4'h0, linkLost = 4'h0, sensBypSw, sensBypComm;
  logic [3:0] oosBypSw, oosBypComm, divActTrip, solenoidOn, sensBypAlarm, oosAlarm, accumBypActive;
  logic hreadyout, hresp, fullScram, sdBypIndicate, nonCoincEnable, valveBusBypEnable;
  logic startupMonBypass, accumSwAlarm, coincSelAlarm;
  int failures = 0, comparisons = 0, n;
  protection_bypass_interlock #(.SD_DELAY_CYCLES(28'h14)) dut (.hready(hreadyout), .*);
  console_model partner (.*);
  always #25 sys_clk = ~sys_clk;
  task automatic w(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do w(1); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do w(1); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic clr;
    divReset <= 4'hF;
    w(4);
    divReset <= 4'h0;
    manReset <= 1'b1;
    w(1);
    manReset <= 1'b0;
  endtask
  task automatic trip(input logic [3:0] m);
    divManTrip <= m;
    w(1);
    divManTrip <= 4'h0;
    w(5);
  endtask
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    w(4000);
    failures++;
    finish_test();
  end
  initial begin
    w(3);
    chk("resetState", {fullScram, solenoidOn, divActTrip, sensBypAlarm, oosAlarm}, 17'h10F00);
    rst_n <= 1'b1;
    w(6);
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk("status", rd & 32'h3F0F, 32'h1D0F);
    ahb(1'b1, 32'h8, 32'h2, rd);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk("stagger", rd, 32'h2);
    ahb(1'b0, 32'hC, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    chk("okay", {hreadyout, hresp}, 2'h2);
    $display("end of reset and bus test");
    foreach (rows[i]) begin
      modeSel <= rows[i].m;
      nonCoincSel <= rows[i].ncs;
      accumBypSw <= rows[i].acc;
      w(6);
      chk("enables", {nonCoincEnable, valveBusBypEnable, startupMonBypass}, rows[i].en);
      chk("alarms", {coincSelAlarm, accumSwAlarm}, rows[i].alm);
      chk("accum", accumBypActive, rows[i].act);
    end
    modeSel <= `MODE_REFUEL;
    w(6);
    clr();
    for (n = 0; n < 20 && solenoidOn === 4'h0; n++) w(1);
    chk("pair", solenoidOn, 4'h3);
    for (n = 0; n < 20 && solenoidOn !== 4'hF; n++) w(1);
    chk("staggerGap", 32'(n), 32'h3);
    chk("cleared", fullScram, 1'b0);
    $display("end of mode and reset test");
    sensReq <= 4'h2;
    w(6);
    chk("sensAlarm", sensBypAlarm, 4'h2);
    sensReq <= 4'h6;
    w(6);
    chk("sensHold", sensBypAlarm, 4'h2);
    sensReq <= 4'h0;
    w(6);
    sensReq <= 4'h9;
    w(6);
    chk("sensTie", sensBypAlarm, 4'h0);
    {sensReq, oosReq, linkLost} <= 12'h444;
    w(6);
    chk("lostLink", {sensBypAlarm, oosAlarm}, 8'h0);
    {sensReq, oosReq, linkLost} <= 12'h0;
    w(6);
    {sensReq, oosReq} <= 8'h22;
    w(6);
    oosReq <= 4'hA;
    w(6);
    chk("bothBypass", {sensBypAlarm, oosAlarm}, 8'h22);
    sensTrip <= 16'h0110;
    w(6);
    chk("voteOne", {fullScram, divActTrip}, 5'h0);
    sensTrip <= 16'h1110;
    w(6);
    chk("voteTwo", {fullScram, divActTrip}, 5'h1D);
    clr();
    w(4);
    chk("resetRefused", fullScram, 1'b1);
    trip(4'h2);
    chk("oosManual", divActTrip, 4'hF);
    {sensTrip, sensReq, oosReq} <= 24'h0;
    w(4);
    clr();
    w(8);
    chk("autoCleared", {fullScram, divActTrip}, 5'h0);
    $display("end of bypass test");
    trip(4'h5);
    chk("twoManual", {fullScram, divActTrip}, 5'h15);
    clr();
    w(12);
    manScram <= 2'h2;
    w(5);
    chk("manScram", {fullScram, solenoidOn}, 5'h10);
    manScram <= 2'h0;
    w(4);
    chk("sealed", fullScram, 1'b1);
    clr();
    w(4);
    chk("manReset", fullScram, 1'b0);
    modeSel <= `MODE_SHUTDOWN;
    w(6);
    chk("sdScram", {fullScram, sdBypIndicate}, 2'h2);
    w(SD + 4);
    chk("sdBypass", sdBypIndicate, 1'b1);
    clr();
    w(4);
    chk("sdReset", fullScram, 1'b0);
    {modeSel, outage, sdReq} <= {`MODE_REFUEL, 3'h7};
    w(6);
    modeSel <= `MODE_SHUTDOWN;
    w(6);
    chk("sdSwitch", {fullScram, sdBypIndicate}, 2'h1);
    $display("end of scram test");
    finish_test();
  end
endmodule // protection_bypass_interlock_test
